/* File: bench/dcp_command_port_sva.sv */
module dcp_command_port_sva #(
  parameter int NUM_CH = 4
) (
  input wire logic              i_clock,
  input wire logic              i_sys_rst,
  input wire logic [7:0]        i_io_addr,
  input wire logic [7:0]        i_io_wdata,
  input wire logic              i_io_rd,
  input wire logic              i_io_wr,
  input wire logic              o_io_ready,
  input wire logic [7:0]        o_rd_data,
  input wire logic              o_rd_valid,
  input wire logic              i_rd_ready,
  input wire logic [NUM_CH-1:0] i_ack_grant,
  input wire logic [NUM_CH-1:0] o_transfer_acknowledge,
  input wire logic [NUM_CH-1:0] o_request_pending,
  input wire logic              o_extended_write,
  input wire logic              o_rotating_priority,
  input wire logic              o_compressed_timing,
  input wire logic              o_controller_disable,
  input wire logic              o_ch0_address_hold,
  input wire logic              o_m2m_enable,
  input wire logic              o_byte_pointer_toggle
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr(logic [7:0] a);
    i_io_wr && o_io_ready && i_io_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_io_rd && !i_io_wr && o_io_ready && i_io_addr == a;
  endsequence
  property p_cmd;
    s_wr(8'hD0) |-> ##2 {2'b00, o_extended_write, o_rotating_priority, o_compressed_timing,
      o_controller_disable, o_ch0_address_hold, o_m2m_enable}
      == ($past(i_io_wdata, 2) & 8'h3F);
  endproperty
  property p_ack;
    s_wr(8'hD0) |-> ##2
      o_transfer_acknowledge == ($past(i_ack_grant) ^ {NUM_CH{~$past(i_io_wdata[7], 2)}});
  endproperty
  cmd_bits_a: assert property (p_cmd)
    else $error("command outputs differ from written byte");
  ack_pol_a: assert property (p_ack)
    else $error("acknowledge polarity wrong");
  ptr_set_a: assert property (s_rd(8'hD8) |-> ##2 o_byte_pointer_toggle)
    else $error("pointer not set by read");
  ptr_clr_a: assert property (s_wr(8'hD8) |-> ##2 !o_byte_pointer_toggle)
    else $error("pointer not cleared by write");
  master_clear_a: assert property (s_wr(8'hDA) |-> ##2 (o_request_pending == '0 &&
    !o_byte_pointer_toggle && !o_controller_disable && !o_m2m_enable))
    else $error("master clear incomplete");
  rd_answer_a: assert property (i_io_rd && !i_io_wr && o_io_ready && !o_rd_valid
    |=> o_rd_valid) else $error("read answer late");
  rd_hold_a: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
    else $error("stalled answer changed");
  dis_gate_a: assert property (o_controller_disable |-> o_request_pending == '0)
    else $error("request pending while disabled");
endmodule

bind dcp_command_port dcp_command_port_sva #(.NUM_CH(NUM_CH)) u_sva (.i_clock, .i_sys_rst,
  .i_io_addr, .i_io_wdata, .i_io_rd, .i_io_wr, .o_io_ready, .o_rd_data, .o_rd_valid,
  .i_rd_ready, .i_ack_grant, .o_transfer_acknowledge, .o_request_pending, .o_extended_write,
  .o_rotating_priority, .o_compressed_timing, .o_controller_disable, .o_ch0_address_hold,
  .o_m2m_enable, .o_byte_pointer_toggle);

/* File: bench/dcp_command_port_tb.sv */
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

module dcp_command_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clock = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [7:0] addr, wdata, rd_data, v;
  logic [7:0] pbus = 8'h00;
  logic       rd, wr, ready, rd_valid, rd_ready, ext, rot, comp, dis, hold, m2m_en, ptr;
  logic       m2m = 1'b0;
  logic [3:0] req = 4'h0;
  logic [3:0] grant = 4'h5;
  logic [3:0] ack, pend;
  int         bad_count = 0;
  int         total_checks = 0;
  always #25 i_clock = ~i_clock;
  dcp_host_model host (.i_clock(i_clock), .i_io_ready(ready), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_io_addr(addr), .o_io_wdata(wdata), .o_io_rd(rd), .o_io_wr(wr),
    .o_rd_ready(rd_ready));
  dcp_command_port #(.NUM_CH(4)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_io_addr(addr), .i_io_wdata(wdata), .i_io_rd(rd), .i_io_wr(wr), .o_io_ready(ready),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready),
    .i_transfer_request_in(req), .i_ack_grant(grant), .i_peripheral_data_bus(pbus),
    .i_m2m_first_cycle(m2m), .o_transfer_acknowledge(ack), .o_request_pending(pend),
    .o_extended_write(ext), .o_rotating_priority(rot), .o_compressed_timing(comp),
    .o_controller_disable(dis), .o_ch0_address_hold(hold), .o_m2m_enable(m2m_en),
    .o_byte_pointer_toggle(ptr));
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.rd(a, r);
    `CHK(n, e, r)
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.put(1'b1, a, d);
    repeat (2) @(negedge i_clock);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // whole sequence needs about 230 cycles; over twenty times that is a hang
  initial begin
    repeat (5000) @(posedge i_clock);
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge i_clock);
    i_sys_rst = 1'b0;
    rchk("cmd", 8'hD4, 8'h00);
    rchk("req", 8'hD2, 8'hF0);
    `CHK("ack", 4'hA, ack)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wreg(8'hD0, 8'h01 << i);
      rchk("cmdrb", 8'hD4, 8'h01 << i);
      `CHK("cmdout", (8'h01 << i) & 8'h3F, {2'b00, ext, rot, comp, dis, hold, m2m_en})
      `CHK("ack", grant ^ {4{i != 7}}, ack)
    end
    $display("test command done");
    wreg(8'hD0, 8'h00);
    for (int c = 0; c < 4; c++) wreg(8'hD4, 8'(c));
    wreg(8'hD2, 8'h06);
    wreg(8'hD2, 8'h07);
    wreg(8'hD2, 8'hFA);
    rchk("req", 8'hD2, 8'hF8);
    `CHK("pend", 4'h8, pend)
    wreg(8'hD4, 8'hFF);
    `CHK("pend", 4'h0, pend)
    wreg(8'hD0, 8'h40);
    req = 4'h2;
    repeat (2) @(negedge i_clock);
    `CHK("pend", 4'h5, pend)
    wreg(8'hD0, 8'h44);
    `CHK("pend", 4'h0, pend)
    $display("test requests done");
    pbus = 8'h5A;
    m2m = 1'b1;
    @(negedge i_clock);
    m2m = 1'b0;
    pbus = 8'hA5;
    rchk("temp", 8'hDA, 8'h5A);
    wreg(8'hDA, 8'h3C);
    rchk("cmd", 8'hD4, 8'h00);
    rchk("req", 8'hD2, 8'hF0);
    rchk("temp", 8'hDA, 8'h00);
    `CHK("pend", 4'h0, pend)
    $display("test clear done");
    wreg(8'hD8, 8'h00);
    wreg(8'hC0, 8'h34);
    wreg(8'hC0, 8'h12);
    rchk("lo", 8'hC0, 8'h34);
    rchk("hi", 8'hC0, 8'h12);
    host.rd(8'hD8, v);
    `CHK("ptr", 1'b1, ptr)
    rchk("hi", 8'hC0, 8'h12);
    host.rd(8'hD8, v);
    wreg(8'hD8, 8'h00);
    `CHK("ptr", 1'b0, ptr)
    $display("test pointer done");
    for (int c = 0; c < 4; c++) wreg(8'hD6, 8'(c * 69));
    host.rd(8'hD6, v);
    host.rd(8'hDC, v);
    for (int k = 0; k < 5; k++) rchk("mode", 8'hD6, 8'((k % 4) * 69));
    $display("test mode done");
    wreg(8'hD0, 8'h11);
    grant = 4'h3;
    repeat (2) @(negedge i_clock);
    `CHK("ack", 4'hC, ack)
    host.set_ready(1'b0);
    host.put(1'b0, 8'hD4, 8'h00);
    host.put(1'b0, 8'hE0, 8'h00);
    @(negedge i_clock);
    `CHK("full", 1'b0, ready)
    `CHK("head", 8'h11, rd_data)
    host.set_ready(1'b1);
    host.get(v);
    `CHK("first", 8'h11, v)
    host.get(v);
    `CHK("unmapped", 8'hFF, v)
    `CHK("empty", 1'b0, rd_valid)
    $display("test buffer done");
    report_and_stop;
  end
endmodule

/* File: bench/dcp_host_model.sv */
module dcp_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_io_ready,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic      [7:0] o_io_addr,
  output logic      [7:0] o_io_wdata,
  output logic            o_io_rd,
  output logic            o_io_wr,
  output logic            o_rd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_io_addr = 8'h00;
    o_io_wdata = 8'h00;
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
    o_rd_ready = 1'b1;
  end
  // request is held until an edge sees ready, then released with inverted lines
  // no local limit: a request never taken is caught by the bench watchdog as a failure
  task automatic put(input bit w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_io_addr = a;
    o_io_wdata = d;
    o_io_wr = w;
    o_io_rd = !w;
    while (i_io_ready !== 1'b1) begin
      @(negedge i_clock);
    end
    @(negedge i_clock);
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
    o_io_addr = ~a;
    o_io_wdata = ~d;
  endtask
  task automatic get(output logic [7:0] d);
    while (i_rd_valid !== 1'b1) begin
      @(negedge i_clock);
    end
    d = i_rd_data;
    @(negedge i_clock);
  endtask
  task automatic set_ready(input bit r);
    o_rd_ready = r;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    get(d);
  endtask
endmodule

/* File: pkg/dcp_defines.svh */
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
// i/o port offsets
`define DCP_CHREG_BASE      8'hC0
`define DCP_CMD_WR_PORT     8'hD0
`define DCP_SWREQ_PORT      8'hD2
`define DCP_CMD_RD_PORT     8'hD4
`define DCP_MASK1_PORT      8'hD4
`define DCP_MODE_PORT       8'hD6
`define DCP_BPTR_PORT       8'hD8
`define DCP_TEMP_PORT       8'hDA
`define DCP_MCLR_PORT       8'hDA
`define DCP_MCNT_PORT       8'hDC
// field positions
`define DCP_SEL_BIT         2
`define DCP_CMD_ACK_POL     7
`define DCP_CMD_REQ_POL     6
`define DCP_CMD_EXT_WR      5
`define DCP_CMD_ROTATE      4
`define DCP_CMD_COMPRESS    3
`define DCP_CMD_DISABLE     2
`define DCP_CMD_HOLD0       1
`define DCP_CMD_M2M         0
// reset values, read fill values and answer buffer depth
`define DCP_CMD_RST         8'h00
`define DCP_REQ_RST         4'h0
`define DCP_MASK_RST        4'hF
`define DCP_TEMP_RST        8'h00
`define DCP_MODE_RST        6'h00
`define DCP_REQ_RD_FILL     4'hF
`define DCP_UNMAPPED_RD     8'hFF
`define DCP_BUF_DEPTH       2
`endif

/* File: pkg/dcp_pkg.sv */
package dcp_pkg;
  typedef logic [7:0]  dcp_byte_t;
  typedef logic [15:0] dcp_word_t;
  typedef logic [5:0]  dcp_mode_t;
  typedef logic [1:0]  dcp_chan_t;
endpackage

/* File: rtl/dcp_command_port.sv */
`include "dcp_defines.svh"

// Function
// [RULE_01] software request port write sets or clears selected channel request by bit 2
// [RULE_02] command readback port returns the stored command byte
// [RULE_03] command bit 7 picks acknowledge polarity, zero low, one high
// [RULE_04] command bit 6 picks request input polarity, zero high, one low
// [RULE_05] command bit 5 selects early extended write strobes
// [RULE_06] command bit 4 selects rotating instead of fixed priority
// [RULE_07] command bit 3 selects compressed two-clock transfer timing
// [RULE_08] command bit 2 disables the whole controller
// [RULE_09] command bit 1 holds channel 0 address in memory-to-memory mode
// [RULE_10] command bit 0 enables memory-to-memory transfers on channels 0 and 1
// [RULE_11] single mask port write sets or clears selected channel mask by bit 2
// [RULE_12] mode register holds type, direction, autoinit, transfer type and channel
// [RULE_13] read at pointer port sets the byte pointer toggle
// [RULE_14] write at pointer port clears the byte pointer toggle
// [RULE_15] temporary register captures peripheral data on first memory-to-memory cycle
// [RULE_16] master clear write clears command, requests, pointer, sets all masks
// [RULE_17] read at mode counter port resets the mode readback counter
// [RULE_18] successive mode reads return channel 0 through channel 3 in order
// [RULE_19] address and count byte access picks low or high byte by pointer
// [RULE_20] pointer toggles after each address or count byte access
// [RULE_21] mode readback counter advances after each mode read, wrapping after 3
module dcp_command_port #(
  parameter int NUM_CH = 4
) (
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  input  wire logic [7:0]        i_io_addr,
  input  wire logic [7:0]        i_io_wdata,
  input  wire logic              i_io_rd,
  input  wire logic              i_io_wr,
  output logic                   o_io_ready,
  output logic [7:0]             o_rd_data,
  output logic                   o_rd_valid,
  input  wire logic              i_rd_ready,
  input  wire logic [NUM_CH-1:0] i_transfer_request_in,
  input  wire logic [NUM_CH-1:0] i_ack_grant,
  input  wire logic [7:0]        i_peripheral_data_bus,
  input  wire logic              i_m2m_first_cycle,
  output logic [NUM_CH-1:0]      o_transfer_acknowledge,
  output logic [NUM_CH-1:0]      o_request_pending,
  output logic                   o_extended_write,
  output logic                   o_rotating_priority,
  output logic                   o_compressed_timing,
  output logic                   o_controller_disable,
  output logic                   o_ch0_address_hold,
  output logic                   o_m2m_enable,
  output logic                   o_byte_pointer_toggle
);

  dcp_pkg::dcp_byte_t            command_r;
  dcp_pkg::dcp_byte_t            temp_r;
  logic [NUM_CH-1:0]             swreq_r;
  logic [NUM_CH-1:0]             mask_r;
  dcp_pkg::dcp_mode_t            mode_r     [NUM_CH];
  dcp_pkg::dcp_word_t            base_addr_r[NUM_CH];
  dcp_pkg::dcp_word_t            cur_addr_r [NUM_CH];
  dcp_pkg::dcp_word_t            base_cnt_r [NUM_CH];
  dcp_pkg::dcp_word_t            cur_cnt_r  [NUM_CH];
  dcp_pkg::dcp_chan_t            mode_cnt_r;
  logic                          bptr_r;
  logic [1:0]                    buf_cnt_r;
  logic [1:0]                    buf_cnt_nxt;
  dcp_pkg::dcp_byte_t            spare_r;
  dcp_pkg::dcp_byte_t            rd_word;
  logic                          acc_rd;
  logic                          acc_wr;
  logic                          pop;
  logic                          chreg_hit;
  logic                          mclr;
  dcp_pkg::dcp_chan_t            sel_ch;
  dcp_pkg::dcp_chan_t            reg_ch;
  logic                          reg_is_cnt;
  logic [NUM_CH-1:0]             req_eff;
  logic                          wr_cmd;
  logic                          wr_swreq;
  logic                          wr_mask;
  logic                          wr_mode;
  logic                          wr_bptr;
  logic                          rd_bptr;
  logic                          rd_mode;
  logic                          rd_mcnt;
  logic                          acc_chreg;

  // reset images of the per-channel flags, one bit per channel
  localparam logic [NUM_CH-1:0] REQ_RST  = NUM_CH'(`DCP_REQ_RST);
  localparam logic [NUM_CH-1:0] MASK_RST = NUM_CH'(`DCP_MASK_RST);

  // a write in the same cycle as a read wins; nothing is taken while the
  // answer buffer is full, so a stalled reader never loses a read result
  assign acc_wr     = i_io_wr & o_io_ready;
  assign acc_rd     = i_io_rd & ~i_io_wr & o_io_ready;
  assign pop        = o_rd_valid & i_rd_ready;
  assign mclr       = acc_wr & (i_io_addr == `DCP_MCLR_PORT);
  assign sel_ch     = i_io_wdata[1:0];
  assign chreg_hit  = (i_io_addr[7:4] == 4'(`DCP_CHREG_BASE >> 4)) & ~i_io_addr[0];
  assign reg_ch     = i_io_addr[3:2];
  assign reg_is_cnt = i_io_addr[1];
  assign req_eff    = i_transfer_request_in ^ {NUM_CH{command_r[`DCP_CMD_REQ_POL]}}; // RULE_04
  assign wr_cmd     = acc_wr & (i_io_addr == `DCP_CMD_WR_PORT);
  assign wr_swreq   = acc_wr & (i_io_addr == `DCP_SWREQ_PORT);
  assign wr_mask    = acc_wr & (i_io_addr == `DCP_MASK1_PORT);
  assign wr_mode    = acc_wr & (i_io_addr == `DCP_MODE_PORT);
  assign wr_bptr    = acc_wr & (i_io_addr == `DCP_BPTR_PORT);
  assign rd_bptr    = acc_rd & (i_io_addr == `DCP_BPTR_PORT);
  assign rd_mode    = acc_rd & (i_io_addr == `DCP_MODE_PORT);
  assign rd_mcnt    = acc_rd & (i_io_addr == `DCP_MCNT_PORT);
  // any taken byte access to an address or count register moves the pointer
  assign acc_chreg  = (acc_rd | acc_wr) & chreg_hit;

  // command register
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || mclr) begin
      command_r <= `DCP_CMD_RST; // RULE_16
    end else if (wr_cmd) begin
      command_r <= i_io_wdata;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam dcp_pkg::dcp_chan_t CH = dcp_pkg::dcp_chan_t'(ch);

      always_ff @(posedge i_clock) begin
        if (i_sys_rst || mclr) begin
          swreq_r[ch] <= REQ_RST[ch]; // RULE_16
        end else if (wr_swreq && sel_ch == CH) begin
          swreq_r[ch] <= i_io_wdata[`DCP_SEL_BIT]; // RULE_01
        end
      end

      always_ff @(posedge i_clock) begin
        if (i_sys_rst || mclr) begin
          mask_r[ch] <= MASK_RST[ch]; // RULE_16
        end else if (wr_mask && sel_ch == CH) begin
          mask_r[ch] <= i_io_wdata[`DCP_SEL_BIT]; // RULE_11
        end
      end

      // mode keeps bits 7:2; the channel field is the write's own selector
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          mode_r[ch] <= `DCP_MODE_RST;
        end else if (wr_mode && sel_ch == CH) begin
          mode_r[ch] <= i_io_wdata[7:2]; // RULE_12
        end
      end

      // writes load base and current together, one byte per pointer state
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          base_addr_r[ch] <= '0;
          cur_addr_r[ch]  <= '0;
        end else if (acc_wr && chreg_hit && reg_ch == CH && !reg_is_cnt) begin
          if (!bptr_r) begin
            base_addr_r[ch][7:0] <= i_io_wdata; // RULE_19
            cur_addr_r[ch][7:0]  <= i_io_wdata;
          end else begin
            base_addr_r[ch][15:8] <= i_io_wdata; // RULE_19
            cur_addr_r[ch][15:8]  <= i_io_wdata;
          end
        end
      end

      // base copies are kept for the reload logic of the transfer engine
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          base_cnt_r[ch] <= '0;
          cur_cnt_r[ch]  <= '0;
        end else if (acc_wr && chreg_hit && reg_ch == CH && reg_is_cnt) begin
          if (!bptr_r) begin
            base_cnt_r[ch][7:0] <= i_io_wdata; // RULE_19
            cur_cnt_r[ch][7:0]  <= i_io_wdata;
          end else begin
            base_cnt_r[ch][15:8] <= i_io_wdata; // RULE_19
            cur_cnt_r[ch][15:8]  <= i_io_wdata;
          end
        end
      end
    end
  endgenerate

  // byte pointer toggle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || mclr) begin
      bptr_r <= 1'b0; // RULE_16
    end else if (rd_bptr) begin
      bptr_r <= 1'b1; // RULE_13
    end else if (wr_bptr) begin
      bptr_r <= 1'b0; // RULE_14
    end else if (acc_chreg) begin
      bptr_r <= ~bptr_r; // RULE_20
    end
  end

  // temporary register
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || mclr) begin
      temp_r <= `DCP_TEMP_RST; // RULE_15
    end else if (i_m2m_first_cycle) begin
      temp_r <= i_peripheral_data_bus; // RULE_15
    end
  end

  // mode readback counter
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode_cnt_r <= '0;
    end else if (rd_mcnt) begin
      mode_cnt_r <= '0; // RULE_17
    end else if (rd_mode) begin
      mode_cnt_r <= mode_cnt_r + 2'd1; // RULE_21
    end
  end

  // read data selection
  always_comb begin
    rd_word = `DCP_UNMAPPED_RD;
    if (chreg_hit) begin
      if (reg_is_cnt) begin
        rd_word = bptr_r ? cur_cnt_r[reg_ch][15:8] : cur_cnt_r[reg_ch][7:0]; // RULE_19
      end else begin
        rd_word = bptr_r ? cur_addr_r[reg_ch][15:8] : cur_addr_r[reg_ch][7:0];
      end
    end else begin
      case (i_io_addr)
        `DCP_SWREQ_PORT: begin
          rd_word = {`DCP_REQ_RD_FILL, swreq_r};
        end
        `DCP_CMD_RD_PORT: begin
          rd_word = command_r; // RULE_02
        end
        `DCP_MODE_PORT: begin
          rd_word = {mode_r[mode_cnt_r], mode_cnt_r}; // RULE_18
        end
        `DCP_TEMP_PORT: begin
          rd_word = temp_r;
        end
        `DCP_BPTR_PORT, `DCP_MCNT_PORT: begin
          rd_word = 8'h00;
        end
        default: begin
          rd_word = `DCP_UNMAPPED_RD;
        end
      endcase
    end
  end

  // two-entry answer buffer: o_rd_data is the head, spare_r the second word
  always_comb begin
    buf_cnt_nxt = buf_cnt_r;
    if (acc_rd && !pop) begin
      buf_cnt_nxt = buf_cnt_r + 2'd1;
    end else if (pop && !acc_rd) begin
      buf_cnt_nxt = buf_cnt_r - 2'd1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      buf_cnt_r <= '0;
    end else begin
      buf_cnt_r <= buf_cnt_nxt;
    end
  end

  // valid and ready follow the next count, so both stay flops without lagging a cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= buf_cnt_nxt != 2'd0;
    end
  end

  // refusing while full is what keeps a stalled reader from losing an answer
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_io_ready <= 1'b1;
    end else begin
      o_io_ready <= buf_cnt_nxt != 2'(`DCP_BUF_DEPTH);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
      spare_r   <= 8'h00;
    end else if (acc_rd && pop) begin
      if (buf_cnt_r == 2'd1) begin
        o_rd_data <= rd_word;
      end else begin
        o_rd_data <= spare_r;
        spare_r   <= rd_word;
      end
    end else if (acc_rd) begin
      if (buf_cnt_r == 2'd0) begin
        o_rd_data <= rd_word;
      end else begin
        spare_r <= rd_word;
      end
    end else if (pop) begin
      o_rd_data <= spare_r;
    end
  end

  // registered pin and mode outputs
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_transfer_acknowledge <= {NUM_CH{1'b1}};
    end else begin
      // zero: active low, so an idle grant drives the pins high
      o_transfer_acknowledge <= i_ack_grant ^ {NUM_CH{~command_r[`DCP_CMD_ACK_POL]}}; // RULE_03
    end
  end

  // masked or disabled channels never show a request, whatever the pins do
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_request_pending <= '0;
    end else begin
      o_request_pending <= (req_eff | swreq_r) & ~mask_r
                           & ~{NUM_CH{command_r[`DCP_CMD_DISABLE]}}; // RULE_08
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_extended_write     <= 1'b0;
      o_rotating_priority  <= 1'b0;
      o_compressed_timing  <= 1'b0;
      o_controller_disable <= 1'b0;
      o_ch0_address_hold   <= 1'b0;
      o_m2m_enable         <= 1'b0;
    end else begin
      o_extended_write     <= command_r[`DCP_CMD_EXT_WR]; // RULE_05
      o_rotating_priority  <= command_r[`DCP_CMD_ROTATE]; // RULE_06
      o_compressed_timing  <= command_r[`DCP_CMD_COMPRESS]; // RULE_07
      o_controller_disable <= command_r[`DCP_CMD_DISABLE]; // RULE_08
      o_ch0_address_hold   <= command_r[`DCP_CMD_HOLD0]; // RULE_09
      o_m2m_enable         <= command_r[`DCP_CMD_M2M]; // RULE_10
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_byte_pointer_toggle <= 1'b0;
    end else begin
      o_byte_pointer_toggle <= bptr_r;
    end
  end

endmodule
